// file: design/sac_pkg.sv
package sac_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ = 125;
  // acquisition window after each conversion, least time
  localparam int ACQ_NS = 250;
  localparam int ACQ_CYC = (ACQ_NS * CLK_MHZ + 999) / 1000;
  // settling time of one successive approximation step, longest time
  localparam int BIT_NS = 40;
  localparam int BIT_CYC = (BIT_NS * CLK_MHZ) / 1000;

  // ****************************************************************
  // result and interface modes
  // ****************************************************************
  localparam int RES_W = 18;
  localparam logic [17:0] MIDSCALE_BIN = 18'h20000;
  localparam logic [4:0] SER_BITS = 5'h12;
  localparam logic [1:0] MODE_PAR18 = 2'h0;
  localparam logic [1:0] MODE_WORD16 = 2'h1;
  localparam logic [1:0] MODE_BYTE8 = 2'h2;
  localparam logic [1:0] MODE_SERIAL = 2'h3;
  localparam int PIN_CODING = 0;
  localparam int PIN_WORD = 1;
  localparam int PIN_BYTE = 2;
  localparam int PIN_SDOUT = 10;
  localparam int PIN_SCLK = 11;
  localparam int PIN_RDERR = 13;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] RES_OFS = 8'h08;
  localparam int CTRL_REFOFF_BIT = 0;
  localparam int CTRL_IMP_BIT = 1;
  localparam int CTRL_FAST_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PD_BIT = 1;
  localparam int STAT_MODE_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ACQ, ST_PWRDN} sacState_e;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } sacAxiReq_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sacAxiRsp_s;

endpackage : sac_pkg

// file: design/sac_adc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// (RULE1) output bus enabled only with select and read low
// (RULE2) select gates the external serial clock
// (RULE3) reset pin high aborts conversion, restores reset
// (RULE4) power-down finishes conversion, then blocks starts
// (RULE5) start falling edge holds sample, starts conversion
// (RULE6) impulse mode: start low at acquisition end converts
// (RULE7) buffer control low enables reference buffer
// (RULE8) two select inputs choose the output interface
// (RULE9) word and byte selects pick result part
// (RULE10) busy high from start until result latched
// (RULE11) coding select picks binary or twos complement; 18-bit parallel mode always gives binary
// (RULE12) idle bus and unused lines are released, except that serial mode drives unused lines 12 and 14 to 17 low
module sac_adc_ctrl
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire sacAxiReq_s axiReq,
  output sacAxiRsp_s axiRsp,
  // host control pins
  input wire logic csN,
  input wire logic rdN,
  input wire logic adcReset,
  input wire logic power_down_req,
  input wire logic conversion_start_n,
  input wire logic iface_sel_hi,
  input wire logic iface_sel_lo,
  // data bus pins, three signals each
  input wire logic [17:0] dataIn,
  output logic [17:0] dataOut,
  output logic [17:0] dataOe,
  output logic busy,
  // analog core
  input wire logic compBit,
  output logic [17:0] dacCode,
  output logic holdTrack,
  output logic refBufEnable
);

  // ****************************************************************
  // conversion control
  // ****************************************************************
  sacState_e state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [4:0] bitIdx_r, bitIdx_nxt;
  logic [17:0] sar_r, sar_nxt;
  logic [17:0] result_r, result_nxt;
  logic busy_r, busy_nxt;
  logic cnvPrev_r, cnvPrev_nxt;
  logic convDone;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic impulseMode;
  logic [1:0] mode;

  assign mode = {iface_sel_hi, iface_sel_lo}; // [RULE8]
  assign impulseMode = ctrl_r[CTRL_IMP_BIT] & ~ctrl_r[CTRL_FAST_BIT];

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    bitIdx_nxt = bitIdx_r;
    sar_nxt = sar_r;
    result_nxt = result_r;
    busy_nxt = busy_r;
    cnvPrev_nxt = conversion_start_n;
    convDone = 1'b0;
    unique case (state_r)
      ST_IDLE:
      begin
        if (power_down_req) // [RULE4]
        begin
          state_nxt = ST_PWRDN;
        end
        else if (cnvPrev_r && !conversion_start_n) // [RULE5]
        begin
          state_nxt = ST_CONV;
          sar_nxt = MIDSCALE_BIN;
          bitIdx_nxt = 5'(RES_W - 1);
          cnt_nxt = 8'(BIT_CYC - 1);
          busy_nxt = 1'b1; // [RULE10]
        end
      end
      ST_CONV:
      begin
        // a raised power-down does not cut the running conversion short
        if (cnt_r != 8'h00) // [RULE4]
        begin
          cnt_nxt = cnt_r - 8'h01;
        end
        else
        begin
          sar_nxt[bitIdx_r] = compBit;
          if (bitIdx_r != 5'h00)
          begin
            sar_nxt[bitIdx_r - 5'h01] = 1'b1;
            bitIdx_nxt = bitIdx_r - 5'h01;
            cnt_nxt = 8'(BIT_CYC - 1);
          end
          else
          begin
            result_nxt = sar_nxt;
            busy_nxt = 1'b0; // [RULE10]
            convDone = 1'b1;
            state_nxt = ST_ACQ;
            cnt_nxt = 8'(ACQ_CYC - 1);
          end
        end
      end
      ST_ACQ:
      begin
        if (cnt_r != 8'h00)
        begin
          cnt_nxt = cnt_r - 8'h01;
        end
        else if (power_down_req) // [RULE4]
        begin
          state_nxt = ST_PWRDN;
        end
        else if (impulseMode && !conversion_start_n) // [RULE6]
        begin
          state_nxt = ST_CONV;
          sar_nxt = MIDSCALE_BIN;
          bitIdx_nxt = 5'(RES_W - 1);
          cnt_nxt = 8'(BIT_CYC - 1);
          busy_nxt = 1'b1;
        end
        else
        begin
          state_nxt = ST_IDLE;
        end
      end
      ST_PWRDN:
      begin
        if (!power_down_req) // [RULE4]
        begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    // the reset pin wins over every state, even mid-conversion
    if (adcReset) // [RULE3]
    begin
      state_nxt = ST_IDLE;
      cnt_nxt = 8'h00;
      bitIdx_nxt = 5'h00;
      sar_nxt = 18'h00000;
      result_nxt = 18'h00000;
      busy_nxt = 1'b0;
      convDone = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      bitIdx_r <= 5'h00;
      sar_r <= 18'h00000;
      result_r <= 18'h00000;
      busy_r <= 1'b0;
      cnvPrev_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bitIdx_r <= bitIdx_nxt;
      sar_r <= sar_nxt;
      result_r <= result_nxt;
      busy_r <= busy_nxt;
      cnvPrev_r <= cnvPrev_nxt;
    end
  end

  assign busy = busy_r;
  assign dacCode = sar_r;
  assign holdTrack = (state_r == ST_CONV); // [RULE5]
  assign refBufEnable = ~ctrl_r[CTRL_REFOFF_BIT]; // [RULE7]

  // ****************************************************************
  // output port and serial shifter
  // ****************************************************************
  logic [17:0] coded;
  logic [17:0] shift_r, shift_nxt;
  logic [4:0] serCnt_r, serCnt_nxt;
  logic sclkPrev_r, sclkPrev_nxt;
  logic rdErr_r, rdErr_nxt;
  logic [17:0] dout_r, dout_nxt;
  logic [17:0] doe_r, doe_nxt;
  logic gatedSclk;
  logic readEn;

  // outside 18-bit parallel mode, coding pin low selects twos complement: flip the sign bit
  assign coded = (mode != MODE_PAR18 && !dataIn[PIN_CODING]) ?
                 (result_r ^ MIDSCALE_BIN) : result_r; // [RULE11]
  assign readEn = !csN && !rdN; // [RULE1]
  assign gatedSclk = dataIn[PIN_SCLK] & ~csN; // [RULE2]

  always_comb
  begin
    shift_nxt = shift_r;
    serCnt_nxt = serCnt_r;
    sclkPrev_nxt = gatedSclk;
    rdErr_nxt = 1'b0;
    dout_nxt = 18'h00000;
    doe_nxt = 18'h00000;
    if (convDone)
    begin
      // a serial read still part way through loses its data
      rdErr_nxt = (serCnt_r != 5'h00) && (serCnt_r < SER_BITS);
      // load the fresh result: result_r still holds the previous one in this cycle
      shift_nxt = (mode != MODE_PAR18 && !dataIn[PIN_CODING]) ?
                  (result_nxt ^ MIDSCALE_BIN) : result_nxt; // [RULE11]
      serCnt_nxt = 5'h00;
    end
    else if (mode == MODE_SERIAL && gatedSclk && !sclkPrev_r) // [RULE2]
    begin
      shift_nxt = {shift_r[16:0], 1'b0};
      if (serCnt_r < SER_BITS)
      begin
        serCnt_nxt = serCnt_r + 5'h01;
      end
    end
    if (readEn) // [RULE12]
    begin
      unique case (mode)
        MODE_PAR18:
        begin
          dout_nxt = result_r;
          doe_nxt = 18'h3ffff;
        end
        MODE_WORD16: // [RULE9]
        begin
          doe_nxt = 18'h3fffc;
          if (!dataIn[PIN_WORD])
          begin
            dout_nxt = {coded[17:2], 2'h0};
          end
          else
          begin
            dout_nxt = {14'h0000, coded[1:0], 2'h0};
          end
        end
        MODE_BYTE8: // [RULE9]
        begin
          doe_nxt = 18'h3fc00;
          unique case ({dataIn[PIN_WORD], dataIn[PIN_BYTE]})
            2'h0: dout_nxt = {coded[17:10], 10'h000};
            2'h1: dout_nxt = {coded[9:2], 10'h000};
            2'h2: dout_nxt = {6'h00, coded[1:0], 10'h000};
            2'h3: dout_nxt = {coded[1:0], 16'h0000};
          endcase
        end
        MODE_SERIAL:
        begin
          doe_nxt = 18'h3f400;
          dout_nxt[PIN_SDOUT] = shift_r[17];
          dout_nxt[PIN_RDERR] = rdErr_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_r <= 18'h00000;
      serCnt_r <= 5'h00;
      sclkPrev_r <= 1'b0;
      rdErr_r <= 1'b0;
      dout_r <= 18'h00000;
      doe_r <= 18'h00000;
    end
    else
    begin
      shift_r <= shift_nxt;
      serCnt_r <= serCnt_nxt;
      sclkPrev_r <= sclkPrev_nxt;
      rdErr_r <= rdErr_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
    end
  end

  assign dataOut = dout_r;
  assign dataOe = doe_r;

  // ****************************************************************
  // register slave
  // ****************************************************************
  logic awHeld_r, awHeld_nxt;
  logic [7:0] awAddr_r, awAddr_nxt;
  logic wHeld_r, wHeld_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic bValid_r, bValid_nxt;
  logic [1:0] bResp_r, bResp_nxt;
  logic rValid_r, rValid_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [1:0] rResp_r, rResp_nxt;
  logic awTake, wTake, arTake;

  assign awTake = axiReq.awvalid && !awHeld_r && !bValid_r;
  assign wTake = axiReq.wvalid && !wHeld_r && !bValid_r;
  assign arTake = axiReq.arvalid && !rValid_r;

  always_comb
  begin
    awHeld_nxt = awHeld_r | awTake;
    awAddr_nxt = awTake ? axiReq.awaddr : awAddr_r;
    wHeld_nxt = wHeld_r | wTake;
    wData_nxt = wTake ? axiReq.wdata : wData_r;
    wStrb_nxt = wTake ? axiReq.wstrb : wStrb_r;
    bValid_nxt = bValid_r & ~axiReq.bready;
    bResp_nxt = bResp_r;
    ctrl_nxt = ctrl_r;
    rValid_nxt = rValid_r & ~axiReq.rready;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    if (awHeld_r && wHeld_r && !bValid_r)
    begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt = RESP_OKAY;
      if ({awAddr_r[7:2], 2'h0} == CTRL_OFS)
      begin
        if (wStrb_r[0])
        begin
          ctrl_nxt = wData_r[2:0];
        end
      end
      else if ({awAddr_r[7:2], 2'h0} != STAT_OFS && {awAddr_r[7:2], 2'h0} != RES_OFS)
      begin
        bResp_nxt = RESP_SLVERR;
      end
    end
    if (arTake)
    begin
      rValid_nxt = 1'b1;
      rResp_nxt = RESP_OKAY;
      rData_nxt = 32'h00000000;
      unique case ({axiReq.araddr[7:2], 2'h0})
        CTRL_OFS: rData_nxt = {29'h0, ctrl_r};
        STAT_OFS:
        begin
          rData_nxt[STAT_BUSY_BIT] = busy_r;
          rData_nxt[STAT_PD_BIT] = (state_r == ST_PWRDN);
          rData_nxt[STAT_MODE_LSB +: 2] = mode;
        end
        RES_OFS: rData_nxt = {14'h0000, result_r};
        default: rResp_nxt = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHeld_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= 2'h0;
      ctrl_r <= CTRL_RST;
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= 2'h0;
    end
    else
    begin
      awHeld_r <= awHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wHeld_r <= wHeld_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bValid_r <= bValid_nxt;
      bResp_r <= bResp_nxt;
      ctrl_r <= ctrl_nxt;
      rValid_r <= rValid_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
    end
  end

  assign axiRsp.awready = !awHeld_r && !bValid_r;
  assign axiRsp.wready = !wHeld_r && !bValid_r;
  assign axiRsp.bvalid = bValid_r;
  assign axiRsp.bresp = bResp_r;
  assign axiRsp.arready = !rValid_r;
  assign axiRsp.rvalid = rValid_r;
  assign axiRsp.rdata = rData_r;
  assign axiRsp.rresp = rResp_r;

endmodule : sac_adc_ctrl

`default_nettype wire

// file: bench/sac_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// comparator of the analog core
// ***
module sac_core_model
(
  // trial code in, decision out
  input wire logic [17:0] dacCode,
  input wire logic [17:0] level,
  output logic compBit
);
  // a trial bit stays while the held level reaches the trial code
  assign compBit = (dacCode <= level);
endmodule : sac_core_model
`default_nettype wire

// file: bench/sac_adc_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// port checker
// ***
module sac_adc_ctrl_sva
  import sac_pkg::*;
(
  // clock, reset and bus
  input wire logic clk,
  input wire logic resetn,
  input wire sacAxiReq_s axiReq,
  input wire sacAxiRsp_s axiRsp,
  // pins
  input wire logic csN,
  input wire logic rdN,
  input wire logic adcReset,
  input wire logic power_down_req,
  input wire logic conversion_start_n,
  input wire logic iface_sel_hi,
  input wire logic iface_sel_lo,
  input wire logic [17:0] dataOe,
  input wire logic busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic rd;
  logic [1:0] md;
  logic [7:0] busyCnt_r, busyCnt_nxt;
  assign rd = !csN && !rdN;
  assign md = {iface_sel_hi, iface_sel_lo};
  // pulse length kept in a counter so one compare covers the whole count
  always_comb
    busyCnt_nxt = busy ? busyCnt_r + 8'h1 : 8'h0;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      busyCnt_r <= 8'h0;
    else
      busyCnt_r <= busyCnt_nxt;
  bus_idle_a: assert property (!rd |=> dataOe == 18'h0)
    else $error("bus driven outside a read");
  par_lines_a: assert property (rd && md == MODE_PAR18 |=> dataOe == 18'h3ffff)
    else $error("parallel lines wrong");
  word_lines_a: assert property (rd && md == MODE_WORD16 |=> dataOe == 18'h3fffc)
    else $error("word lines wrong");
  byte_lines_a: assert property (rd && md == MODE_BYTE8 |=> dataOe == 18'h3fc00)
    else $error("byte lines wrong");
  ser_lines_a: assert property (rd && md == MODE_SERIAL |=> dataOe == 18'h3f400)
    else $error("serial lines wrong");
  start_cause_a: assert property ($rose(busy) |-> !$past(conversion_start_n)
    && !$past(power_down_req) && !$past(adcReset))
    else $error("busy rose without a start");
  busy_len_a: assert property ($fell(busy) && !$past(adcReset) |-> busyCnt_r == 18 * BIT_CYC)
    else $error("busy length wrong");
  reset_abort_a: assert property (adcReset |=> !busy)
    else $error("busy kept through reset");
  bresp_hold_a: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid)
    else $error("write response dropped");
endmodule : sac_adc_ctrl_sva
bind sac_adc_ctrl sac_adc_ctrl_sva sac_adc_ctrl_sva_i (.clk, .resetn, .axiReq, .axiRsp,
  .csN, .rdN, .adcReset, .power_down_req, .conversion_start_n, .iface_sel_hi,
  .iface_sel_lo, .dataOe, .busy);
`default_nettype wire

// file: bench/sac_adc_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sac_adc_ctrl_bench
  import sac_pkg::*;
;
  localparam logic [17:0] VAL = 18'h2a5c3;
  logic clk, resetn, csN, rdN, adcReset, pdReq, startN, compBit, busy, refBufEnable;
  logic hold;
  logic [1:0] md, r;
  logic [17:0] dataIn, dataOut, dataOe, dacCode, level;
  logic [31:0] q;
  sacAxiReq_s axiReq;
  sacAxiRsp_s axiRsp;
  int numErrors, testsRun, n, busyLen;
  // ***
  // design and analog core
  // ***
  sac_adc_ctrl sac_adc_ctrl_i (.clk, .resetn, .axiReq, .axiRsp, .csN, .rdN, .adcReset,
    .power_down_req(pdReq), .conversion_start_n(startN), .iface_sel_hi(md[1]),
    .iface_sel_lo(md[0]), .dataIn, .dataOut, .dataOe, .busy, .compBit, .dacCode,
    .holdTrack(hold), .refBufEnable);
  sac_core_model sac_core_model_i (.dacCode, .level, .compBit);
  // length of the last busy pulse, counted apart from any bus traffic in between
  always @(posedge clk)
    busyLen <= busy ? busyLen + 1 : (startN ? busyLen : 0);
  initial
  begin
    clk = 1'b0;
    forever
      #4 clk = ~clk;
  end
  task automatic chk(input string s, input logic [35:0] e, input logic [35:0] g);
    testsRun++;
    if (g !== e)
    begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic hang;
    numErrors++;
    summarize();
  endtask : hang
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // handshakes are sampled at the falling edge, where nothing moves
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic hA, hW, hD;
    hD = 1'b0;
    n = 0;
    axiReq.awaddr <= a;
    axiReq.araddr <= a;
    axiReq.wdata <= d;
    axiReq.awvalid <= wr;
    axiReq.wvalid <= wr;
    axiReq.bready <= wr;
    axiReq.arvalid <= !wr;
    axiReq.rready <= !wr;
    while (!hD)
    begin
      @(negedge clk);
      hA = wr ? axiRsp.awready : axiRsp.arready;
      hW = axiRsp.wready;
      hD = wr ? axiRsp.bvalid : axiRsp.rvalid;
      q = axiRsp.rdata;
      r = wr ? axiRsp.bresp : axiRsp.rresp;
      @(posedge clk);
      axiReq.awvalid <= axiReq.awvalid && !hA;
      axiReq.arvalid <= axiReq.arvalid && !hA;
      axiReq.wvalid <= axiReq.wvalid && !hW;
      n++;
      if (n > 50)
        hang();
    end
    axiReq.bready <= 1'b0;
    axiReq.rready <= 1'b0;
    @(posedge clk);
  endtask : axi
  task automatic waitBusy(input logic lvl);
    n = 0;
    @(negedge clk);
    while (busy !== lvl)
    begin
      n++;
      if (n > 300)
        hang();
      @(negedge clk);
    end
    @(posedge clk);
  endtask : waitBusy
  task automatic go(input logic [17:0] v);
    level <= v;
    startN <= 1'b0;
    waitBusy(1'b1);
    startN <= 1'b1;
  endtask : go
  task automatic done;
    waitBusy(1'b0);
    chk("busy cycles", 18 * BIT_CYC, busyLen);
    tick(ACQ_CYC + 2);
  endtask : done
  function automatic logic [35:0] expBus(input logic [1:0] m, input logic [1:0] s,
    input logic [17:0] c);
    case (m)
      MODE_PAR18: return {18'h3ffff, c};
      MODE_WORD16: return {18'h3fffc, s[1] ? {14'h0, c[1:0]} : c[17:2], 2'h0};
      MODE_BYTE8: return {18'h3fc00, s == 2'h0 ? c[17:10] : s == 2'h1 ? c[9:2] :
        s == 2'h2 ? {6'h0, c[1:0]} : {c[1:0], 6'h0}, 10'h0};
      default: return {18'h3f400, 7'h0, c[17], 10'h0};
    endcase
  endfunction : expBus
  // ***
  // scenarios
  // ***
  task automatic testRegs;
    axi(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl reset", {refBufEnable, q}, {1'b1, 29'h0, CTRL_RST});
    axi(1'b1, CTRL_OFS, 32'h1);
    chk("buffer off", 0, refBufEnable);
    axi(1'b0, 8'h20, 32'h0);
    chk("unmapped", {RESP_SLVERR, 32'h0}, {r, q});
    axi(1'b1, CTRL_OFS, 32'h0);
    $display("register test done");
  endtask : testRegs
  task automatic testConv;
    go(VAL);
    chk("holding", 1, hold);
    axi(1'b0, STAT_OFS, 32'h0);
    chk("busy flag", 1, q[STAT_BUSY_BIT]);
    done();
    chk("tracking", 0, hold);
    axi(1'b0, RES_OFS, 32'h0);
    chk("result", VAL, q);
    $display("conversion test done");
  endtask : testConv
  task automatic testBus;
    logic [17:0] c;
    logic [35:0] e;
    csN <= 1'b0;
    rdN <= 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      md <= i[4:3];
      dataIn <= {15'h0, i[2:0]};
      tick(2);
      // the shift register was loaded in parallel mode, so it holds the raw result
      c = (md == MODE_PAR18 || md == MODE_SERIAL || i[0]) ? VAL : VAL ^ MIDSCALE_BIN;
      e = expBus(md, {i[1], i[2]}, c);
      chk("data bus", e, {dataOe, dataOut & dataOe});
    end
    rdN <= 1'b1;
    tick(2);
    chk("read off", 0, dataOe);
    csN <= 1'b1;
    $display("data bus test done");
  endtask : testBus
  // clock pulses while deselected must not move the shift register
  task automatic testSerial;
    rdN <= 1'b0;
    dataIn <= 18'h0;
    // a fresh conversion in serial mode with twos complement coding
    go(~VAL);
    done();
    for (int k = 19; k > 13; k--)
    begin
      csN <= k > 17;
      tick(3);
      if (k < 18)
        chk("serial bit", !VAL[k] ^ MIDSCALE_BIN[k], dataOut[PIN_SDOUT]);
      dataIn[PIN_SCLK] <= 1'b1;
      tick(2);
      dataIn[PIN_SCLK] <= 1'b0;
    end
    csN <= 1'b1;
    rdN <= 1'b1;
    $display("serial test done");
  endtask : testSerial
  task automatic testReset;
    go(18'h3ffff);
    tick(20);
    adcReset <= 1'b1;
    tick(1);
    adcReset <= 1'b0;
    tick(2);
    chk("aborted", 0, busy);
    axi(1'b0, RES_OFS, 32'h0);
    chk("result cleared", 0, q);
    $display("reset test done");
  endtask : testReset
  task automatic testPower;
    go(18'h15555);
    pdReq <= 1'b1;
    done();
    axi(1'b0, STAT_OFS, 32'h0);
    chk("powered down", {2'h2, MODE_SERIAL}, {q[STAT_PD_BIT], q[STAT_BUSY_BIT], q[3:2]});
    startN <= 1'b0;
    tick(100);
    chk("start refused", 0, busy);
    startN <= 1'b1;
    pdReq <= 1'b0;
    axi(1'b0, RES_OFS, 32'h0);
    chk("finished", 18'h15555, q);
    $display("power test done");
  endtask : testPower
  task automatic testImpulse;
    axi(1'b1, CTRL_OFS, 32'h2);
    level <= 18'h00abc;
    startN <= 1'b0;
    waitBusy(1'b1);
    waitBusy(1'b0);
    waitBusy(1'b1);
    chk("restart", ACQ_CYC - 1, n);
    startN <= 1'b1;
    done();
    $display("impulse test done");
  endtask : testImpulse
  initial
  begin
    {resetn, csN, rdN, adcReset, pdReq, startN} = 6'h19;
    {md, dataIn, level} = '0;
    axiReq = '{wstrb: 4'hf, default: '0};
    tick(8);
    resetn <= 1'b1;
    tick(1);
    testRegs();
    testConv();
    testBus();
    testSerial();
    testReset();
    testPower();
    testImpulse();
    summarize();
  end
endmodule : sac_adc_ctrl_bench
`default_nettype wire
